// ===== core/icl_top.sv
// Purpose: Interrupt control logic between peripherals and processor core.
// Assumes: Core gives a one-cycle Q1 pulse per instruction cycle.
// Notes: Registers are reached over classic Wishbone, one byte per word.
// Summary of operation
// - Reset clears global, peripheral and all source enables.
// - Vector needs global enable, source enable, and peripheral enable if needed.
// - Source flags set on events regardless of any enable.
// - Entry flushes prefetch, clears global enable and pushes the program counter.
// - Entry copies working, status, bank, pointer and latch registers to shadow.
// - Entry loads the program counter with vector 0004h.
// - Flags stay set until software clears; set flag retriggers after return.
// - Events during service routine set flags without redirecting.
// - Return pops stack into program counter, restores shadow, sets global enable.
// - Pending enabled request is serviced once global enable is set again.
// - Pending requests are sampled on the Q1 phase of each cycle.
// - Latency depends on when the request is detected within the instruction cycle.
// - Seven source enable registers and seven matching flag registers exist.
// - Control register holds global, peripheral enable and edge select bits.
// - External pin flags rising edge when select is one, falling when zero.
// - Sources of the first enable register need no peripheral enable.
// - Latency three to five cycles, whatever the current instruction length.
// - After wake, the instruction after sleep runs before the vector.
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module icl_top
  import icl_pkg::*;
#(
  parameter int CTX_W = ICL_CTX_W
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ICL_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt sources
  input wire logic ext_pin_i,
  input wire logic [ICL_NSRC-1:0] src_event_i,
  // Core timing and state
  input wire logic core_q1_i,
  input wire logic core_sleep_i,
  input wire logic [ICL_PC_W-1:0] core_pc_i,
  input wire logic [CTX_W-1:0] core_ctx_i,
  // Return from service routine
  input wire logic return_from_isr_i,
  input wire logic [ICL_PC_W-1:0] stack_pop_i,
  // Entry, return and wake actions
  output logic flush_o,
  output logic push_pc_o,
  output logic [ICL_PC_W-1:0] push_data_o,
  output logic pc_load_o,
  output logic [ICL_PC_W-1:0] pc_load_addr_o,
  output logic ctx_restore_o,
  output logic [CTX_W-1:0] ctx_shadow_o,
  output logic wake_o,
  // Block interrupt
  output logic irq_o
);
  // ==========================================================================
  // Declarations
  typedef enum logic [1:0] {ICL_RUN, ICL_SERVE, ICL_WAKE_SKIP} icl_state_e;
  icl_state_e state_reg;
  icl_flag_if fl ();
  logic [7:0] ctrl_reg;
  logic [7:0] en_reg [ICL_NREG];
  logic [ICL_NSRC-1:0] en_flat;
  logic [ICL_EVT_W-1:0] evt_stat_reg;
  logic [ICL_EVT_W-1:0] evt_en_reg;
  logic [ICL_EVT_W-1:0] evt_set;
  logic pin_prev_reg;
  logic pin_prime_reg;
  logic ext_edge;
  logic [ICL_NSRC-1:0] active;
  logic pend_first;
  logic pend_periph;
  logic pend;
  logic take;
  logic wake_hit;
  logic global_irq_enable;
  logic bus_req;
  logic bus_wr;
  logic [ICL_IDX_W-1:0] idx;
  logic [7:0] rd_byte;
  // ==========================================================================
  // Flag bank
  icl_flag_bank u_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .fl(fl.bank)
  );
  // ==========================================================================
  // External pin edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_prev_reg <= 1'b0;
      pin_prime_reg <= 1'b0;
    end
    else
    begin
      pin_prev_reg <= ext_pin_i;
      pin_prime_reg <= 1'b1;
    end
  end
  always_comb
  begin
    ext_edge = 1'b0;
    if (pin_prime_reg)
    begin
      if (ctrl_reg[ICL_BIT_EDGE])
        ext_edge = ext_pin_i & ~pin_prev_reg;
      else
        ext_edge = ~ext_pin_i & pin_prev_reg;
    end
  end
  // Bit 0 of the first register is the external pin flag.
  assign fl.set = src_event_i | {{(ICL_NSRC-1){1'b0}}, ext_edge};
  // ==========================================================================
  // Bus decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[ICL_ADR_W-1:2];
  assign fl.wr_data = wb_dat_i[7:0];
  genvar gr;
  generate
    for (gr = 0; gr < ICL_NREG; gr = gr + 1)
    begin : g_reg
      assign fl.wr_en[gr] =
        bus_wr && (idx == ICL_IDX_FLAG_BASE + ICL_IDX_W'(gr));
      assign en_flat[gr*8 +: 8] = en_reg[gr];
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          en_reg[gr] <= ICL_BYTE_RST;
        else if (bus_wr && (idx == ICL_IDX_EN_BASE + ICL_IDX_W'(gr)))
          en_reg[gr] <= wb_dat_i[7:0];
      end
    end
  endgenerate
  // ==========================================================================
  // Pending request evaluation
  assign active = fl.flags & en_flat;
  assign global_irq_enable = ctrl_reg[ICL_BIT_GIE];
  assign pend_first = |active[7:0];
  assign pend_periph = ctrl_reg[ICL_BIT_PERIPHERAL_IRQ_ENABLE] & (|active[ICL_NSRC-1:8]);
  assign pend = pend_first | pend_periph;
  // Sampling only on Q1 fixes the latency window at a few instruction cycles.
  assign take = core_q1_i && global_irq_enable && pend && !core_sleep_i &&
    (state_reg == ICL_RUN);
  assign wake_hit = core_sleep_i && pend && !wake_o;
  // ==========================================================================
  // Sequencing
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= ICL_RUN;
    else
    begin
      case (state_reg)
        ICL_RUN:
        begin
          if (take)
            state_reg <= ICL_SERVE;
          else if (wake_hit && global_irq_enable)
            state_reg <= ICL_WAKE_SKIP;
        end
        ICL_SERVE:
        begin
          // The ICL_RUN check in take already gates new entries during service.
          if (return_from_isr_i)
            state_reg <= ICL_RUN;
        end
        ICL_WAKE_SKIP:
        begin
          // One Q1 passes while the instruction after sleep runs.
          if (core_q1_i && !core_sleep_i)
            state_reg <= ICL_RUN;
        end
        default:
          state_reg <= ICL_RUN;
      endcase
    end
  end
  // ==========================================================================
  // Control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= ICL_CTRL_RST;
    else if (take)
      ctrl_reg[ICL_BIT_GIE] <= 1'b0;
    else if (return_from_isr_i)
      ctrl_reg[ICL_BIT_GIE] <= 1'b1;
    else if (bus_wr && idx == ICL_IDX_CTRL)
      ctrl_reg <= wb_dat_i[7:0] & ICL_CTRL_MASK;
  end
  // ==========================================================================
  // Entry actions and return program counter load
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flush_o <= 1'b0;
      push_pc_o <= 1'b0;
      push_data_o <= ICL_PC_RST;
    end
    else
    begin
      flush_o <= take;
      push_pc_o <= take;
      if (take)
        push_data_o <= core_pc_i;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc_load_o <= 1'b0;
      pc_load_addr_o <= ICL_PC_RST;
    end
    else
    begin
      pc_load_o <= take | return_from_isr_i;
      if (take)
        pc_load_addr_o <= ICL_VECTOR;
      else if (return_from_isr_i)
        pc_load_addr_o <= stack_pop_i;
    end
  end
  // ==========================================================================
  // Shadow context
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctx_shadow_o <= '0;
      ctx_restore_o <= 1'b0;
    end
    else
    begin
      ctx_restore_o <= return_from_isr_i;
      if (take)
        ctx_shadow_o <= core_ctx_i;
    end
  end
  // ==========================================================================
  // Wake from sleep
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wake_o <= 1'b0;
    else
      wake_o <= wake_hit;
  end
  // ==========================================================================
  // Block event status, enable and interrupt
  always_comb
  begin
    evt_set = ICL_EVT_RST;
    evt_set[ICL_EVT_ENTRY] = take;
    evt_set[ICL_EVT_RETURN] = return_from_isr_i;
    evt_set[ICL_EVT_WAKE] = wake_hit;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_stat_reg <= ICL_EVT_RST;
    else if (bus_wr && idx == ICL_IDX_EVT_CLR)
      evt_stat_reg <= (evt_stat_reg & ~wb_dat_i[ICL_EVT_W-1:0]) | evt_set;
    else
      evt_stat_reg <= evt_stat_reg | evt_set;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_en_reg <= ICL_EVT_RST;
    else if (bus_wr && idx == ICL_IDX_EVT_EN)
      evt_en_reg <= wb_dat_i[ICL_EVT_W-1:0];
  end
  assign irq_o = |(evt_stat_reg & evt_en_reg);
  // ==========================================================================
  // Read mux
  always_comb
  begin
    rd_byte = ICL_BYTE_RST;
    if (idx == ICL_IDX_CTRL)
      rd_byte = ctrl_reg;
    else if (idx == ICL_IDX_EVT_STAT)
      rd_byte = {{(8-ICL_EVT_W){1'b0}}, evt_stat_reg};
    else if (idx == ICL_IDX_EVT_EN)
      rd_byte = {{(8-ICL_EVT_W){1'b0}}, evt_en_reg};
    for (int i = 0; i < ICL_NREG; i++)
    begin
      if (idx == ICL_IDX_EN_BASE + ICL_IDX_W'(i))
        rd_byte = en_reg[i];
      if (idx == ICL_IDX_FLAG_BASE + ICL_IDX_W'(i))
        rd_byte = fl.flags[i*8 +: 8];
    end
  end
  // ==========================================================================
  // Wishbone answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end
endmodule
`default_nettype wire

// ===== include/icl_pkg.sv
// Purpose: Shared constants for the interrupt control logic.
// Assumes: Register index times four gives the Wishbone byte address.
// Notes: Data bytes sit in the low eight bits of the 32-bit bus word.
package icl_pkg;
  // ==========================================================================
  // Sizes
  localparam int ICL_NREG = 7;
  localparam int ICL_NSRC = 56;
  localparam int ICL_ADR_W = 12;
  localparam int ICL_IDX_W = 10;
  // ==========================================================================
  // Register indices
  localparam logic [9:0] ICL_IDX_CTRL = 10'h00b;
  localparam logic [9:0] ICL_IDX_EN_BASE = 10'h096;
  localparam logic [9:0] ICL_IDX_FLAG_BASE = 10'h08c;
  localparam logic [9:0] ICL_IDX_EVT_STAT = 10'h100;
  localparam logic [9:0] ICL_IDX_EVT_CLR = 10'h101;
  localparam logic [9:0] ICL_IDX_EVT_EN = 10'h102;
  // ==========================================================================
  // Control register fields and reset value
  localparam int ICL_BIT_GIE = 7;
  localparam int ICL_BIT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int ICL_BIT_EDGE = 0;
  localparam logic [7:0] ICL_CTRL_RST = 8'h01;
  localparam logic [7:0] ICL_CTRL_MASK = 8'hc1;
  localparam logic [7:0] ICL_BYTE_RST = 8'h00;
  // ==========================================================================
  // Block event bits
  localparam int ICL_EVT_W = 3;
  localparam int ICL_EVT_ENTRY = 0;
  localparam int ICL_EVT_RETURN = 1;
  localparam int ICL_EVT_WAKE = 2;
  localparam logic [2:0] ICL_EVT_RST = 3'h0;
  // ==========================================================================
  // Core side
  localparam int ICL_PC_W = 15;
  localparam logic [14:0] ICL_VECTOR = 15'h0004;
  localparam logic [14:0] ICL_PC_RST = 15'h0000;
  localparam int ICL_CTX_W = 64;
endpackage

// ===== include/icl_flag_if.sv
// Purpose: Carries request flag set, write and read between top and bank.
// Assumes: One clock domain.
// Notes: Flags are packed register by register, bit 0 lowest.
`timescale 1ns/1ps
`default_nettype none
interface icl_flag_if;
  import icl_pkg::*;
  logic [ICL_NSRC-1:0] set;
  logic [ICL_NREG-1:0] wr_en;
  logic [7:0] wr_data;
  logic [ICL_NSRC-1:0] flags;
  modport bank (input set, input wr_en, input wr_data, output flags);
  modport ctrl (output set, output wr_en, output wr_data, input flags);
endinterface
`default_nettype wire

// ===== core/icl_flag_bank.sv
// Purpose: Holds the request flags of all sources.
// Assumes: Set pulses and writes are synchronous to clk_i.
// Notes: A set in the same cycle as a write wins over the write.
`timescale 1ns/1ps
`default_nettype none
module icl_flag_bank
  import icl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Flag access
  icl_flag_if.bank fl
);
  // ==========================================================================
  // Flag bits
  genvar gi;
  generate
    for (gi = 0; gi < ICL_NSRC; gi = gi + 1)
    begin : g_flag
      logic flag_reg;
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          flag_reg <= 1'b0;
        else if (fl.set[gi])
          flag_reg <= 1'b1;
        else if (fl.wr_en[gi/8])
          flag_reg <= fl.wr_data[gi%8];
      end
      assign fl.flags[gi] = flag_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// ===== bench/icl_core_model.sv
// Purpose: Core model with Q1 pulses, program counter, context and return.
// Assumes: One clock; a return is made only when the bench asks.
// Notes: Holds one stacked address; the pop bus is inverted when idle.
`timescale 1ns/1ps
`default_nettype none
module icl_core_model
  import icl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Design side
  input wire logic push_i,
  input wire logic [ICL_PC_W-1:0] push_data_i,
  input wire logic load_i,
  input wire logic [ICL_PC_W-1:0] load_addr_i,
  input wire logic ret_cmd_i,
  output logic q1_o,
  output logic [ICL_PC_W-1:0] pc_o,
  output logic [ICL_CTX_W-1:0] ctx_o,
  output logic ret_o,
  output logic [ICL_PC_W-1:0] pop_o
);
  logic [1:0] ph_reg;
  logic [ICL_PC_W-1:0] stk_reg;
  assign q1_o = (ph_reg == 2'h0);
  assign ctx_o = {4{1'b1, pc_o}};
  assign pop_o = ret_o ? stk_reg : ~stk_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ph_reg <= 2'h0;
      pc_o <= ICL_PC_RST;
      stk_reg <= ICL_PC_RST;
      ret_o <= 1'b0;
    end
    else
    begin
      ph_reg <= ph_reg + 2'h1;
      ret_o <= ret_cmd_i;
      if (push_i)
        stk_reg <= push_data_i;
      if (load_i)
        pc_o <= load_addr_i;
      else if (q1_o)
        pc_o <= pc_o + 15'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== bench/icl_top_assertions.sv
// Purpose: Port-level checks of the interrupt control logic.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Attached to the top module by bind.
`timescale 1ns/1ps
`default_nettype none
module icl_top_assertions
  import icl_pkg::*;
#(
  parameter int CTX_W = ICL_CTX_W
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Core
  input wire logic core_q1_i,
  input wire logic core_sleep_i,
  input wire logic [ICL_PC_W-1:0] core_pc_i,
  input wire logic [CTX_W-1:0] core_ctx_i,
  input wire logic return_from_isr_i,
  input wire logic [ICL_PC_W-1:0] stack_pop_i,
  // Actions
  input wire logic flush_o,
  input wire logic push_pc_o,
  input wire logic [ICL_PC_W-1:0] push_data_o,
  input wire logic pc_load_o,
  input wire logic [ICL_PC_W-1:0] pc_load_addr_o,
  input wire logic ctx_restore_o,
  input wire logic [CTX_W-1:0] ctx_shadow_o,
  input wire logic wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  vec_entry_a: assert property (push_pc_o |-> pc_load_o &&
    pc_load_addr_o == ICL_VECTOR) else $error("entry vector wrong");
  flush_push_a: assert property (flush_o == push_pc_o)
    else $error("flush and push apart");
  entry_q1_a: assert property (flush_o |-> $past(core_q1_i) &&
    !$past(core_sleep_i)) else $error("entry off Q1 or asleep");
  push_pc_a: assert property (push_pc_o |->
    push_data_o == $past(core_pc_i)) else $error("pushed pc wrong");
  ctx_snap_a: assert property (push_pc_o |->
    ctx_shadow_o == $past(core_ctx_i)) else $error("shadow wrong");
  ret_pc_a: assert property (return_from_isr_i |=> pc_load_o &&
    !flush_o && ctx_restore_o && pc_load_addr_o == $past(stack_pop_i))
    else $error("return load wrong");
  ret_only_a: assert property (ctx_restore_o |->
    $past(return_from_isr_i)) else $error("restore without return");
  wake_sleep_a: assert property (wake_o |-> $past(core_sleep_i))
    else $error("wake while awake");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("ack late");
  entry_c: cover property (push_pc_o);
  return_c: cover property (ctx_restore_o);
  wake_c: cover property (wake_o);
endmodule
bind icl_top icl_top_assertions #(.CTX_W(CTX_W)) i_icl_top_assertions (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .core_q1_i,
  .core_sleep_i, .core_pc_i, .core_ctx_i, .return_from_isr_i,
  .stack_pop_i, .flush_o, .push_pc_o, .push_data_o, .pc_load_o,
  .pc_load_addr_o, .ctx_restore_o, .ctx_shadow_o, .wake_o);
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the interrupt control logic.
// Assumes: Core model stands on the far side.
// Notes: Registers are reached through classic Wishbone tasks.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import icl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic ext_pin_i = 1'b0;
  logic [ICL_NSRC-1:0] src_event_i = '0;
  logic core_sleep_i = 1'b0;
  logic ret_cmd = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, core_q1_i, return_from_isr_i, flush_o, push_pc_o;
  logic pc_load_o, ctx_restore_o, wake_o, irq_o;
  logic [ICL_PC_W-1:0] core_pc_i, stack_pop_i, push_data_o, pc_load_addr_o;
  logic [ICL_CTX_W-1:0] core_ctx_i, ctx_shadow_o;
  logic [7:0] q;
  logic [3:0] sel_v = 4'h1;
  int failures = 0;
  int num_checks = 0;
  int entries = 0;
  int wakes = 0;
  int cnt = 0;
  icl_top i_icl_top (.*);
  icl_core_model i_icl_core_model (.clk_i(clk_i), .rst_i(rst_i),
    .push_i(push_pc_o), .push_data_i(push_data_o), .load_i(pc_load_o),
    .load_addr_i(pc_load_addr_o), .ret_cmd_i(ret_cmd), .q1_o(core_q1_i),
    .pc_o(core_pc_i), .ctx_o(core_ctx_i), .ret_o(return_from_isr_i),
    .pop_o(stack_pop_i));
  always #25 clk_i = ~clk_i;
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    if (flush_o === 1'b1)
      entries <= entries + 1;
    if (wake_o === 1'b1)
      wakes <= wakes + 1;
    cnt <= cnt + 1;
    if (cnt == 5000)
    begin
      $display("mismatch at %0t: timeout", $time);
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic [9:0] i, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= sel_v;
    wb_adr_i <= {i, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    wb(i, 1'b0, 8'h00);
    chk(q, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic ev(input int n);
    @(posedge clk_i);
    src_event_i[n] <= 1'b1;
    @(posedge clk_i);
    src_event_i <= '0;
  endtask
  task automatic ent(input int t);
    repeat (30) if (entries != t) @(posedge clk_i);
    chk(8'(entries), 8'(t));
  endtask
  initial
  begin
    idle(8);
    rst_i <= 1'b0;
    rd(ICL_IDX_CTRL, ICL_CTRL_RST);
    for (int k = 0; k < ICL_NREG; k++)
    begin
      rd(ICL_IDX_EN_BASE + 10'(k), 8'h00);
      rd(ICL_IDX_FLAG_BASE + 10'(k), 8'h00);
      wb(ICL_IDX_EN_BASE + 10'(k), 1'b1, 8'ha5);
      rd(ICL_IDX_EN_BASE + 10'(k), 8'ha5);
      wb(ICL_IDX_EN_BASE + 10'(k), 1'b1, 8'h00);
    end
    rd(10'h0ff, 8'h00);
    // A write without the low byte select is acknowledged but ignored.
    sel_v = 4'h0;
    wb(ICL_IDX_EN_BASE + 10'h003, 1'b1, 8'hff);
    sel_v = 4'h1;
    rd(ICL_IDX_EN_BASE + 10'h003, 8'h00);
    ev(9);
    rd(ICL_IDX_FLAG_BASE + 10'h001, 8'h02);
    wb(ICL_IDX_CTRL, 1'b1, 8'h81);
    wb(ICL_IDX_EN_BASE + 10'h001, 1'b1, 8'h02);
    idle(20);
    ent(0);
    wb(ICL_IDX_CTRL, 1'b1, 8'hc1);
    ent(1);
    rd(ICL_IDX_CTRL, 8'h41);
    rd(ICL_IDX_EVT_STAT, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    wb(ICL_IDX_EVT_EN, 1'b1, 8'h01);
    chk({7'h00, irq_o}, 8'h01);
    wb(ICL_IDX_EVT_CLR, 1'b1, 8'h01);
    chk({7'h00, irq_o}, 8'h00);
    wb(ICL_IDX_EN_BASE + 10'h002, 1'b1, 8'h02);
    ev(17);
    idle(20);
    ent(1);
    rd(ICL_IDX_FLAG_BASE + 10'h002, 8'h02);
    wb(ICL_IDX_FLAG_BASE + 10'h002, 1'b1, 8'h00);
    @(posedge clk_i);
    ret_cmd <= 1'b1;
    @(posedge clk_i);
    ret_cmd <= 1'b0;
    ent(2);
    rd(ICL_IDX_FLAG_BASE + 10'h001, 8'h02);
    wb(ICL_IDX_FLAG_BASE + 10'h001, 1'b1, 8'h00);
    rd(ICL_IDX_FLAG_BASE + 10'h001, 8'h00);
    // An event held across a clearing write keeps its flag set.
    src_event_i[9] <= 1'b1;
    wb(ICL_IDX_FLAG_BASE + 10'h001, 1'b1, 8'h00);
    src_event_i <= '0;
    rd(ICL_IDX_FLAG_BASE + 10'h001, 8'h02);
    wb(ICL_IDX_FLAG_BASE + 10'h001, 1'b1, 8'h00);
    @(posedge clk_i);
    ret_cmd <= 1'b1;
    @(posedge clk_i);
    ret_cmd <= 1'b0;
    idle(20);
    ent(2);
    rd(ICL_IDX_CTRL, 8'hc1);
    ext_pin_i <= 1'b1;
    idle(2);
    rd(ICL_IDX_FLAG_BASE, 8'h01);
    wb(ICL_IDX_FLAG_BASE, 1'b1, 8'h00);
    wb(ICL_IDX_CTRL, 1'b1, 8'hc0);
    ext_pin_i <= 1'b0;
    idle(2);
    rd(ICL_IDX_FLAG_BASE, 8'h01);
    wb(ICL_IDX_FLAG_BASE, 1'b1, 8'h00);
    ext_pin_i <= 1'b1;
    idle(2);
    rd(ICL_IDX_FLAG_BASE, 8'h00);
    core_sleep_i <= 1'b1;
    ev(9);
    idle(6);
    core_sleep_i <= 1'b0;
    chk(8'(wakes != 0), 8'h01);
    ent(3);
    rd(ICL_IDX_EVT_STAT, 8'h07);
    rd(ICL_IDX_EVT_EN, 8'h01);
    end_sim();
  end
endmodule
`default_nettype wire
